// >>> src/ocq_pkg.sv
// Constants shared by the overcurrent trip delay qualifier.
`default_nettype none
package ocq_pkg;
    localparam int NUM_CH = 4;
    localparam int CODE_W = 7;
    localparam logic [7:0] CMD_OC_DELAY = 8'h02;
    localparam logic [7:0] CMD_TRIP_DELAY = 8'h03;
    localparam logic [7:0] CMD_THRESH_BASE = 8'h08;
    localparam logic [7:0] CMD_THRESH_LAST = 8'h0B;
    localparam int CLEAR_BIT = 7;
    localparam logic [7:0] TRIP_CFG_RESET = 8'h14;
    localparam logic [7:0] OC_CFG_RESET = 8'h04;
    localparam logic [7:0] THRESH_RESET = 8'hD1;
    localparam logic [7:0] THRESH_DISABLED = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [CODE_W-1:0] COUNT_MAX = 7'h7F;
    localparam logic [CODE_W-1:0] COUNT_ZERO = 7'h00;
endpackage : ocq_pkg
`default_nettype wire

// >>> src/ocq_run_counter.sv
// Consecutive-breach run counter for one channel and one delay setting.
`default_nettype none
module ocq_run_counter (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clear,
    input wire logic i_step,
    input wire logic i_breach,
    input wire logic [ocq_pkg::CODE_W-1:0] i_delay_code,
    output logic o_hit
);
    typedef struct packed {
        logic [ocq_pkg::CODE_W-1:0] run;
    } ocq_run_state_type;

    ocq_run_state_type s_q;
    ocq_run_state_type s_d;

    // The count holds breaches already seen, so code N fires on breach N+1.
    assign o_hit = i_step && i_breach && !i_clear && (s_q.run >= i_delay_code);

    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d.run = ocq_pkg::COUNT_ZERO;
        end else if (i_step) begin
            if (!i_breach) begin
                s_d.run = ocq_pkg::COUNT_ZERO;
            end else if (s_q.run != ocq_pkg::COUNT_MAX) begin
                s_d.run = s_q.run + 7'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ocq_run_counter
`default_nettype wire

// >>> src/ocq_qualifier.sv
// Overcurrent trip delay qualifier with its command-addressed byte registers.
`default_nettype none
module ocq_qualifier (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_cmd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_sample_valid,
    input wire logic [1:0] i_sample_channel,
    input wire logic [7:0] i_sample_code,
    output logic o_trip_output_pin,
    output logic [ocq_pkg::NUM_CH-1:0] o_channel_trip_flag,
    output logic o_alert_request
);
    typedef struct packed {
        logic [7:0] trip_cfg;
        logic [7:0] oc_cfg;
        logic [ocq_pkg::NUM_CH-1:0][7:0] thresh;
        logic trip_latch;
        logic [ocq_pkg::NUM_CH-1:0] oc_flag;
        logic [7:0] rdata;
    } ocq_state_type;

    ocq_state_type s_q;
    ocq_state_type s_d;

    logic trip_clear;
    logic oc_clear;
    logic [ocq_pkg::NUM_CH-1:0] ch_step;
    logic [ocq_pkg::NUM_CH-1:0] ch_breach;
    logic [ocq_pkg::NUM_CH-1:0] trip_hit;
    logic [ocq_pkg::NUM_CH-1:0] oc_hit;

    assign trip_clear = s_q.trip_cfg[ocq_pkg::CLEAR_BIT];
    assign oc_clear = s_q.oc_cfg[ocq_pkg::CLEAR_BIT];

    // Each sample arrives tagged with its channel, so per-channel runs stay apart.
    assign ch_step[0] = i_sample_valid && (i_sample_channel == 2'h0);
    assign ch_breach[0] = (s_q.thresh[0] != ocq_pkg::THRESH_DISABLED)
        && (i_sample_code > s_q.thresh[0]);

    ocq_run_counter u_trip_run_ch0 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(trip_clear),
        .i_step(ch_step[0]),
        .i_breach(ch_breach[0]),
        .i_delay_code(s_q.trip_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(trip_hit[0])
    );

    ocq_run_counter u_oc_run_ch0 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(oc_clear),
        .i_step(ch_step[0]),
        .i_breach(ch_breach[0]),
        .i_delay_code(s_q.oc_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(oc_hit[0])
    );

    assign ch_step[1] = i_sample_valid && (i_sample_channel == 2'h1);
    assign ch_breach[1] = (s_q.thresh[1] != ocq_pkg::THRESH_DISABLED)
        && (i_sample_code > s_q.thresh[1]);

    ocq_run_counter u_trip_run_ch1 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(trip_clear),
        .i_step(ch_step[1]),
        .i_breach(ch_breach[1]),
        .i_delay_code(s_q.trip_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(trip_hit[1])
    );

    ocq_run_counter u_oc_run_ch1 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(oc_clear),
        .i_step(ch_step[1]),
        .i_breach(ch_breach[1]),
        .i_delay_code(s_q.oc_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(oc_hit[1])
    );

    assign ch_step[2] = i_sample_valid && (i_sample_channel == 2'h2);
    assign ch_breach[2] = (s_q.thresh[2] != ocq_pkg::THRESH_DISABLED)
        && (i_sample_code > s_q.thresh[2]);

    ocq_run_counter u_trip_run_ch2 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(trip_clear),
        .i_step(ch_step[2]),
        .i_breach(ch_breach[2]),
        .i_delay_code(s_q.trip_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(trip_hit[2])
    );

    ocq_run_counter u_oc_run_ch2 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(oc_clear),
        .i_step(ch_step[2]),
        .i_breach(ch_breach[2]),
        .i_delay_code(s_q.oc_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(oc_hit[2])
    );

    assign ch_step[3] = i_sample_valid && (i_sample_channel == 2'h3);
    assign ch_breach[3] = (s_q.thresh[3] != ocq_pkg::THRESH_DISABLED)
        && (i_sample_code > s_q.thresh[3]);

    ocq_run_counter u_trip_run_ch3 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(trip_clear),
        .i_step(ch_step[3]),
        .i_breach(ch_breach[3]),
        .i_delay_code(s_q.trip_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(trip_hit[3])
    );

    ocq_run_counter u_oc_run_ch3 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(oc_clear),
        .i_step(ch_step[3]),
        .i_breach(ch_breach[3]),
        .i_delay_code(s_q.oc_cfg[ocq_pkg::CODE_W-1:0]),
        .o_hit(oc_hit[3])
    );

    always_comb begin
        s_d = s_q;
        if (trip_clear) begin
            s_d.trip_latch = 1'b0;
        end else if (|trip_hit) begin
            s_d.trip_latch = 1'b1;
        end

        if (oc_clear) begin
            s_d.oc_flag = '0;
        end else begin
            s_d.oc_flag = s_q.oc_flag | oc_hit;
        end

        // A register write lands after this sample's decision, so it governs later samples.
        // Setting a clear bit also drops its outputs at the write edge, so none stays high while the bit is one.
        if (i_reg_wr) begin
            if (i_reg_cmd == ocq_pkg::CMD_TRIP_DELAY) begin
                s_d.trip_cfg = i_reg_wdata;
                if (i_reg_wdata[ocq_pkg::CLEAR_BIT]) begin
                    s_d.trip_latch = 1'b0;
                end
            end else if (i_reg_cmd == ocq_pkg::CMD_OC_DELAY) begin
                s_d.oc_cfg = i_reg_wdata;
                if (i_reg_wdata[ocq_pkg::CLEAR_BIT]) begin
                    s_d.oc_flag = '0;
                end
            end else if (i_reg_cmd >= ocq_pkg::CMD_THRESH_BASE && i_reg_cmd <= ocq_pkg::CMD_THRESH_LAST) begin
                s_d.thresh[i_reg_cmd[1:0]] = i_reg_wdata;
            end
        end

        // A read in the same cycle as a write returns the value held before that write.
        if (i_reg_rd) begin
            if (i_reg_cmd == ocq_pkg::CMD_TRIP_DELAY) begin
                s_d.rdata = s_q.trip_cfg;
            end else if (i_reg_cmd == ocq_pkg::CMD_OC_DELAY) begin
                s_d.rdata = s_q.oc_cfg;
            end else if (i_reg_cmd >= ocq_pkg::CMD_THRESH_BASE && i_reg_cmd <= ocq_pkg::CMD_THRESH_LAST) begin
                s_d.rdata = s_q.thresh[i_reg_cmd[1:0]];
            end else begin
                s_d.rdata = ocq_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q.trip_cfg <= ocq_pkg::TRIP_CFG_RESET;
            s_q.oc_cfg <= ocq_pkg::OC_CFG_RESET;
            s_q.thresh <= {ocq_pkg::NUM_CH{ocq_pkg::THRESH_RESET}};
            s_q.trip_latch <= 1'b0;
            s_q.oc_flag <= '0;
            s_q.rdata <= ocq_pkg::UNMAPPED_READ;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_trip_output_pin = s_q.trip_latch;
    assign o_channel_trip_flag = s_q.oc_flag;
    assign o_alert_request = |s_q.oc_flag;
    assign o_reg_rdata = s_q.rdata;
endmodule : ocq_qualifier
`default_nettype wire

// >>> tb/ocq_host_model.sv
// Register host and sample source for the qualifier.
`default_nettype none
module ocq_host_model (
    input wire logic i_clk,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_cmd,
    output logic [7:0] o_wdata,
    output logic o_valid,
    output logic [1:0] o_ch,
    output logic [7:0] o_code
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {o_wr, o_rd, o_valid, o_ch, o_cmd, o_wdata, o_code} = 29'h0;
    // Released command, data and code lines show the inverse, so a stale value cannot pass for a fresh one.
    task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d);
        {o_wr, o_rd, o_cmd, o_wdata} = {w, !w, c, d};
        @(negedge i_clk);
        {o_wr, o_rd, o_cmd, o_wdata} = {2'h0, ~c, ~d};
        @(negedge i_clk);
    endtask : acc
    task automatic samp(input logic [1:0] ch, input logic [7:0] v, input int gap);
        {o_valid, o_ch, o_code} = {1'h1, ch, v};
        @(negedge i_clk);
        {o_valid, o_code} = {1'h0, ~v};
        repeat (gap) @(negedge i_clk);
    endtask : samp
endmodule : ocq_host_model
`default_nettype wire

// >>> tb/ocq_qualifier_assertions.sv
// Port assertions for the qualifier.
`default_nettype none
module ocq_qualifier_assertions (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_cmd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_sample_valid,
    input wire logic o_trip_output_pin,
    input wire logic [ocq_pkg::NUM_CH-1:0] o_channel_trip_flag,
    input wire logic o_alert_request
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cfg_q;
    logic occ_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_q <= 8'h14;
            occ_q <= 1'h0;
        end else begin
            if (i_reg_wr && i_reg_cmd == 8'h03) cfg_q <= i_reg_wdata;
            if (i_reg_wr && i_reg_cmd == 8'h02) occ_q <= i_reg_wdata[7];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_cfg_readback: assert property (i_reg_rd && i_reg_cmd == 8'h03 |=> o_reg_rdata == $past(cfg_q))
        else $error("bad trip config read");
    chk_unmapped_zero: assert property (i_reg_rd && i_reg_cmd > 8'h0B |=> o_reg_rdata == 8'h00)
        else $error("bad unmapped read");
    chk_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
    chk_clear_low: assert property (cfg_q[7] |-> !o_trip_output_pin) else $error("trip while cleared");
    chk_trip_sample: assert property ($rose(o_trip_output_pin) |-> $past(i_sample_valid))
        else $error("trip without sample");
    chk_trip_enabled: assert property ($rose(o_trip_output_pin) |-> !$past(cfg_q[7]))
        else $error("trip with clear set");
    chk_trip_sticky: assert property ($fell(o_trip_output_pin) |-> cfg_q[7] || $past(cfg_q[7]))
        else $error("trip dropped");
    chk_flag_clear: assert property (occ_q |-> !(|o_channel_trip_flag)) else $error("flag while cleared");
    chk_alert_or: assert property (o_alert_request == |o_channel_trip_flag) else $error("alert not OR");
    cover property ($rose(o_trip_output_pin));
    cover property (|o_channel_trip_flag);
    cover property (i_reg_rd && i_reg_cmd == 8'h03);
endmodule : ocq_qualifier_assertions
bind ocq_qualifier ocq_qualifier_assertions ocq_qualifier_assertions_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_cmd(i_reg_cmd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_sample_valid(i_sample_valid), .o_trip_output_pin(o_trip_output_pin),
    .o_channel_trip_flag(o_channel_trip_flag), .o_alert_request(o_alert_request));
`default_nettype wire

// >>> tb/ocq_qualifier_tb.sv
// Self-checking bench for the qualifier.
`default_nettype none
module ocq_qualifier_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_resetn, i_reg_wr, i_reg_rd, i_sample_valid, o_trip_output_pin, o_alert_request;
    logic [1:0] i_sample_channel;
    logic [7:0] i_reg_cmd, i_reg_wdata, o_reg_rdata, i_sample_code;
    logic [ocq_pkg::NUM_CH-1:0] o_channel_trip_flag;
    int errors;
    int cmp_count;
    ocq_qualifier ocq_qualifier_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_cmd(i_reg_cmd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_sample_valid(i_sample_valid), .i_sample_channel(i_sample_channel), .i_sample_code(i_sample_code),
        .o_trip_output_pin(o_trip_output_pin), .o_channel_trip_flag(o_channel_trip_flag),
        .o_alert_request(o_alert_request));
    ocq_host_model ocq_host_model_i (.i_clk(i_clk), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_cmd(i_reg_cmd),
        .o_wdata(i_reg_wdata), .o_valid(i_sample_valid), .o_ch(i_sample_channel), .o_code(i_sample_code));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic t(input logic e);
        chk("trip", {7'h00, e}, {7'h00, o_trip_output_pin});
    endtask : t
    task automatic w(input logic [7:0] c, input logic [7:0] d);
        ocq_host_model_i.acc(1'h1, c, d);
    endtask : w
    task automatic r(input logic [7:0] c, input logic [7:0] e);
        ocq_host_model_i.acc(1'h0, c, 8'h00);
        chk("rdata", e, o_reg_rdata);
    endtask : r
    task automatic s(input logic [7:0] v);
        ocq_host_model_i.samp(2'h0, v, 1);
    endtask : s
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
    initial begin
        i_resetn = 1'h0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'h1;
        r(8'h03, 8'h14);
        t(1'h0);
        r(8'h0C, 8'h00);
        $display("reset test done");
        w(8'h02, 8'h00);
        w(8'h08, 8'h10);
        w(8'h03, 8'h02);
        s(8'h20);
        s(8'h20);
        s(8'h05);
        s(8'h20);
        ocq_host_model_i.samp(2'h0, 8'h20, 4);
        t(1'h0);
        s(8'h20);
        t(1'h1);
        chk("alert", 8'h01, {7'h00, o_alert_request});
        $display("run test done");
        w(8'h03, 8'h82);
        t(1'h0);
        r(8'h03, 8'h82);
        repeat (3) s(8'h20);
        t(1'h0);
        w(8'h03, 8'h02);
        repeat (2) s(8'h20);
        t(1'h0);
        s(8'h20);
        t(1'h1);
        $display("restart test done");
        w(8'h03, 8'h80);
        t(1'h0);
        w(8'h03, 8'h00);
        ocq_host_model_i.samp(2'h3, 8'hD2, 1);
        t(1'h1);
        chk("flags", 8'h09, {4'h0, o_channel_trip_flag});
        w(8'h02, 8'h80);
        @(negedge i_clk);
        chk("flags", 8'h00, {4'h0, o_channel_trip_flag});
        chk("alert", 8'h00, {7'h00, o_alert_request});
        $display("clear test done");
        i_resetn = 1'h0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'h1;
        r(8'h03, 8'h14);
        t(1'h0);
        r(8'h02, 8'h04);
        repeat (4) s(8'hD2);
        chk("flags", 8'h00, {4'h0, o_channel_trip_flag});
        s(8'hD2);
        chk("flags", 8'h01, {4'h0, o_channel_trip_flag});
        repeat (15) s(8'hD2);
        t(1'h0);
        s(8'hD2);
        t(1'h1);
        $display("default test done");
        print_verdict();
    end
endmodule : ocq_qualifier_tb
`default_nettype wire
